// [hdl/sclkg_top.sv]
// system clock generator: divider, trim, general control register
`timescale 1ns/1ps
module sclkg_top (
    // clock and reset (CLK is taken as the 20 ns clock of CLK_NS)
    input  wire logic       CLK,
    input  wire logic       RESETN,
    // register port
    input  wire logic [15:0] ADDR,
    input  wire logic       WR_EN,
    input  wire logic       RD_EN,
    input  wire logic [7:0] WDATA,
    output logic      [7:0] RDATA,
    // power-up cause from the power-on reset logic
    input  wire logic       BATT_POWERUP,
    // gpio pins and their frozen copy
    input  wire logic [7:0] GPIO_IN,
    output logic      [7:0] GPIO_HELD,
    output logic            BUTTON_EVENT,
    // clock and power outputs
    output logic            SYS_CLK_EN,
    output logic            CHIP_POWER_DOWN,
    output logic            WAKE_REQ,
    output logic      [7:0] OSC_FREQ_TRIM,
    output logic            TICK_PULSE,
    output logic     [31:0] TICK_COUNT
);
    // whole state in one struct
    typedef struct packed {
        logic [2:0]  div_sel;     // divider code
        logic        hold;        // gpio hold
        logic        pdown;       // shutdown request
        logic        batt;        // battery insert flag
        logic        batt_done;   // flag captured after release
        logic [7:0]  trim;        // oscillator trim
        logic [6:0]  div_cnt;     // divider counter
        logic [2:0]  div_act;     // code actually in use
        logic        clk_en;      // divided clock enable
        logic [7:0]  tick_div;    // tick prescaler
        logic [31:0] tick_cnt;    // tick counter
        logic        tick_p;      // tick pulse
        logic [7:0]  gpio_s1;     // synchroniser stage one
        logic [7:0]  gpio_s2;     // synchroniser stage two
        logic [7:0]  gpio_prev;   // previous synced value
        logic [7:0]  gpio_held;   // frozen gpio output
        logic        btn;         // button event
        logic        btn_pend;    // deferred button
        logic        wake;        // wake request
        logic [7:0]  rdata;       // read data
    } sclkg_state_t;

    sclkg_state_t s_q;  // registered state
    sclkg_state_t s_d;  // next state

    logic wr_ctrl;  // control write strobe
    logic wr_trim;  // trim write strobe
    logic [7:0] fall; // falling edges on gpio
    assign wr_ctrl = WR_EN && (ADDR == sclkg_pkg::GEN_CTRL_ADDR);
    assign wr_trim = WR_EN && (ADDR == sclkg_pkg::OSC_TRIM_ADDR);
    assign fall    = s_q.gpio_prev & ~s_q.gpio_s2;

    // divisor minus one for a code, used by counter and checks
    // divisor two to the code
    function automatic logic [6:0] div_last(input logic [2:0] code);
        div_last = 7'((8'h01 << code) - 8'h01);
    endfunction

    // next-state logic
    always_comb begin
        s_d = s_q;
        // pins are asynchronous: two flops stand before any gpio logic
        s_d.gpio_s1   = GPIO_IN;
        s_d.gpio_s2   = s_q.gpio_s1;
        s_d.gpio_prev = s_q.gpio_s2;
        s_d.btn       = 1'b0;
        s_d.tick_p    = 1'b0;
        if (wr_ctrl) begin
            s_d.pdown   = WDATA[sclkg_pkg::PDOWN_BIT];
            s_d.hold    = WDATA[sclkg_pkg::HOLD_BIT];
            s_d.div_sel = WDATA[sclkg_pkg::DIV_MSB:sclkg_pkg::DIV_LSB];
        end
        if (wr_trim) begin
            s_d.trim = WDATA;
        end
        // new code taken only at period end, no runt pulse
        if (s_q.div_cnt >= div_last(s_q.div_act)) begin
            s_d.div_cnt = 7'h00;
            s_d.clk_en  = 1'b1;
            s_d.div_act = s_q.div_sel;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 7'h01;
            s_d.clk_en  = 1'b0;
        end
        // flag caught once after reset release
        if (!s_q.batt_done) begin
            s_d.batt      = BATT_POWERUP;
            s_d.batt_done = 1'b1;
        end
        // tick prescaler, 5.12 us period
        if (s_q.tick_div == 8'(sclkg_pkg::TICK_CYCLES - 1)) begin
            s_d.tick_div = 8'h00;
            s_d.tick_cnt = s_q.tick_cnt + 32'h1;
            s_d.tick_p   = 1'b1;
        end else begin
            s_d.tick_div = s_q.tick_div + 8'h01;
        end
        if (wr_ctrl && WDATA[sclkg_pkg::TICKCLR_BIT]) begin
            s_d.tick_div = 8'h00;
            s_d.tick_cnt = 32'h0;
        end
        if (!s_q.hold) begin
            s_d.gpio_held = s_q.gpio_s2;
        end
        if (|fall) begin
            if (s_q.hold && !s_q.pdown) begin
                s_d.btn_pend = 1'b1;
            end else if (!s_q.pdown) begin
                s_d.btn = 1'b1;
            end
        end else if (s_q.btn_pend && !s_q.hold) begin
            s_d.btn      = 1'b1;
            s_d.btn_pend = 1'b0;
        end
        // falling edge while down wakes chip
        if (s_q.pdown && ((|fall) || s_q.btn_pend)) begin
            s_d.wake = 1'b1;
        end
        // reserved bit reads zero
        // the write-only clear bit reads back zero too, unmapped reads give zero
        s_d.rdata = 8'h00;
        if (RD_EN && ADDR == sclkg_pkg::GEN_CTRL_ADDR) begin
            s_d.rdata = {s_q.pdown, 1'b0, s_q.batt, 1'b0, s_q.hold, s_q.div_sel};
        end else if (RD_EN && ADDR == sclkg_pkg::OSC_TRIM_ADDR) begin
            s_d.rdata = s_q.trim;
        end
    end

    // state register; wake is cleared only by the power-on reset it causes
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            s_q           <= '0;
            s_q.div_sel   <= sclkg_pkg::DIV_RESET;
            s_q.div_act   <= sclkg_pkg::DIV_RESET;
            s_q.trim      <= sclkg_pkg::TRIM_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign SYS_CLK_EN      = s_q.clk_en;
    assign CHIP_POWER_DOWN = s_q.pdown;
    assign WAKE_REQ        = s_q.wake;
    assign OSC_FREQ_TRIM   = s_q.trim;
    assign TICK_PULSE      = s_q.tick_p;
    assign TICK_COUNT      = s_q.tick_cnt;
    assign GPIO_HELD       = s_q.gpio_held;
    assign BUTTON_EVENT    = s_q.btn;
    assign RDATA           = s_q.rdata;

    divider_period_a: assert property (@(posedge CLK) disable iff (!RESETN)
        s_q.clk_en |=> (s_q.clk_en == ($past(s_q.div_act) == 3'h0)))
        else $error("divider enable spacing wrong");
    // counter never passes the divisor minus one of the code in use
    div_bound_a: assert property (@(posedge CLK) disable iff (!RESETN)
        s_q.div_cnt <= div_last(s_q.div_act))
        else $error("divider counter overran");
    div_reset_a: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(RESETN) |-> s_q.div_sel == 3'h0)
        else $error("divider not zero after reset");
    tick_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (wr_ctrl && WDATA[sclkg_pkg::TICKCLR_BIT]) |=> s_q.tick_cnt == 32'h0)
        else $error("tick counter not cleared");
    gpio_freeze_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (s_q.hold && $past(s_q.hold)) |-> $stable(s_q.gpio_held))
        else $error("gpio changed during hold");
    // a press under hold gives no event yet
    btn_defer_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (s_q.hold && (|fall)) |=> !s_q.btn)
        else $error("button event during hold");
    rsvd_zero_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (RD_EN && ADDR == sclkg_pkg::GEN_CTRL_ADDR) |=> s_q.rdata[sclkg_pkg::RSVD_BIT] == 1'b0
            && s_q.rdata[sclkg_pkg::TICKCLR_BIT] == 1'b0)
        else $error("control read shows reserved or clear bit");
    pdown_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_ctrl |=> s_q.pdown == $past(WDATA[sclkg_pkg::PDOWN_BIT]))
        else $error("power-down not written");
    // wake within one cycle of edge
    wake_edge_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (s_q.pdown && |fall) |=> s_q.wake)
        else $error("no wake on falling edge");
    trim_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wr_trim |=> s_q.trim == $past(WDATA))
        else $error("trim not written");
endmodule // sclkg_top

// [hdl/sclkg_pkg.sv]
// constants for the system clock generator block
package sclkg_pkg;
    // register addresses
    localparam logic [15:0] GEN_CTRL_ADDR  = 16'h00BE;
    localparam logic [15:0] OSC_TRIM_ADDR  = 16'h4002;
    // control register field positions
    localparam int DIV_LSB      = 0;
    localparam int DIV_MSB      = 2;
    localparam int HOLD_BIT     = 3;
    localparam int TICKCLR_BIT  = 4;
    localparam int BATT_BIT     = 5;
    localparam int RSVD_BIT     = 6;
    localparam int PDOWN_BIT    = 7;
    // reset values
    localparam logic [2:0] DIV_RESET  = 3'h0;
    localparam logic [7:0] TRIM_RESET = 8'hFF;
    // timing
    localparam int REF_MHZ      = 24;
    localparam int TICK_NS      = 5120;
    localparam int CLK_NS       = 20;
    localparam int TICK_CYCLES  = TICK_NS / CLK_NS;
endpackage

// [bench/test_system_clock_generator.sv]
// self-checking bench for the system clock generator
`timescale 1ns/1ps
module test_system_clock_generator;
    logic        clk = 1'b0;          // 50 MHz bench clock
    logic        resetn = 1'b0;       // sync reset, active low
    logic [15:0] addr = 16'h0000;     // register address
    logic        wr_en = 1'b0;        // write strobe
    logic        rd_en = 1'b0;        // read strobe
    logic [7:0]  wdata = 8'h00;       // write data
    logic [7:0]  gpio_in = 8'hFF;     // buttons idle high
    logic        batt_powerup = 1'b1; // first power-up came from a battery
    logic [7:0]  rdata, gpio_held, osc_freq_trim;
    logic        button_event, sys_clk_en, chip_power_down, wake_req, tick_pulse;
    logic [31:0] tick_count;
    int          fail_count = 0, check_count = 0, btn_seen = 0, p = 0;

    // free-running clock
    always #10 clk = ~clk;

    sclkg_top dut_u (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
        .WDATA(wdata), .RDATA(rdata), .BATT_POWERUP(batt_powerup), .GPIO_IN(gpio_in),
        .GPIO_HELD(gpio_held), .BUTTON_EVENT(button_event), .SYS_CLK_EN(sys_clk_en),
        .CHIP_POWER_DOWN(chip_power_down), .WAKE_REQ(wake_req), .OSC_FREQ_TRIM(osc_freq_trim),
        .TICK_PULSE(tick_pulse), .TICK_COUNT(tick_count));

    // tally button pulses so a deferred press can be seen later
    always @(posedge clk) if (button_event === 1'b1) btn_seen <= btn_seen + 1;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // inputs move 1 ns after the edge, outputs are settled by then
    task automatic step(input int k);
        repeat (k) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        step(1);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
    endtask

    // read data is registered, so it is looked at one cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        step(1);
        addr = a;
        rd_en = 1'b1;
        step(1);
        rd_en = 1'b0;
        chk(what, {24'h0, exp}, {24'h0, rdata});
    endtask

    // cycles between two enable pulses, bounded so a dead divider cannot hang
    task automatic period(output int q);
        int w;
        w = 0;
        while (sys_clk_en !== 1'b1 && w < 300) begin
            step(1);
            w++;
        end
        q = 0;
        do begin
            step(1);
            q++;
        end while (sys_clk_en !== 1'b1 && q < 300);
    endtask

    // watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end

    initial begin
        step(20);
        resetn = 1'b1;
        rd(16'h4002, 8'hFF, "trim reset");
        rd(16'h00BE, 8'h20, "control reset");
        rd(16'h1234, 8'h00, "unmapped read");
        wr(16'h4002, 8'h00);
        rd(16'h4002, 8'h00, "trim fastest");
        chk("trim pins", 32'h0, {24'h0, osc_freq_trim});
        wr(16'h00BE, 8'h7F);
        rd(16'h00BE, 8'h2F, "control masked bits");
        // every divider code; the first period may still be the old one
        for (int c = 0; c < 8; c++) begin
            wr(16'h00BE, 8'(c));
            period(p);
            period(p);
            chk("divider period", 32'h1 << c, 32'(p));
        end
        chk("tick running", 32'h1, {31'h0, tick_count != 32'h0});
        wr(16'h00BE, 8'h10);
        chk("tick cleared", 32'h0, tick_count);
        // a full tick period after the clear the first pulse comes
        step(sclkg_pkg::TICK_CYCLES - 1);
        chk("tick not yet", 32'h0, {31'h0, tick_pulse});
        step(1);
        chk("tick pulse", 32'h1, {31'h0, tick_pulse});
        chk("tick after clear", 32'h1, tick_count);
        rd(16'h00BE, 8'h20, "clear bit reads zero");
        // hold freezes the port and defers the press until released
        wr(16'h00BE, 8'h08);
        gpio_in = 8'hFE;
        p = btn_seen;
        step(10);
        chk("held port", 32'hFF, {24'h0, gpio_held});
        chk("press deferred", 32'(p), 32'(btn_seen));
        wr(16'h00BE, 8'h00);
        step(10);
        chk("press released", 32'(p + 1), 32'(btn_seen));
        chk("port follows", 32'hFE, {24'h0, gpio_held});
        // hold then power down, a falling pin wakes the chip
        gpio_in = 8'hFF;
        step(5);
        // software sets hold on its own first, then asks for power-down
        wr(16'h00BE, 8'h08);
        wr(16'h00BE, 8'h88);
        chk("power down", 32'h1, {31'h0, chip_power_down});
        gpio_in = 8'hFD;
        step(10);
        chk("wake request", 32'h1, {31'h0, wake_req});
        // wake ends in a reset; this time not from a battery
        resetn = 1'b0;
        batt_powerup = 1'b0;
        step(3);
        resetn = 1'b1;
        chk("wake cleared", 32'h0, {31'h0, wake_req});
        rd(16'h00BE, 8'h00, "gpio power-up flag");
        rd(16'h4002, 8'hFF, "trim after wake");
        give_verdict();
    end
endmodule // test_system_clock_generator
